// >>> inc/mab_cfg.svh
`ifndef MAB_CFG_SVH
`define MAB_CFG_SVH

// ==========================================
// Status register bit positions
`define MAB_FL_C 0
`define MAB_FL_Z 1
`define MAB_FL_N 2
`define MAB_FL_V 3
`define MAB_FL_S 4
`define MAB_FL_H 5
`define MAB_FL_T 6
`define MAB_FL_I 7

// ==========================================
// Reset values and constants
`define MAB_PC_RESET   16'h0000
`define MAB_SREG_RESET 8'h00
`define MAB_ALL_ONES   8'hff
`define MAB_PTR_LO     5'h1e
`define MAB_PTR_HI     5'h1f

// ==========================================
// Cycle counts
`define MAB_CYC_ONE  2'h1
`define MAB_CYC_WORD 2'h2
`define MAB_CYC_JUMP 2'h2
`define MAB_CYC_CALL 2'h3
`define MAB_CYC_RET  3'h4

`endif

// >>> inc/mab_pkg.sv
package mab_pkg;

	// ==========================================
	// Operations accepted by the core
	typedef enum logic [5:0] {
		op_nop,
		op_add,
		op_add_carry,
		op_word_immediate_sum,
		op_sub,
		op_difference_const,
		op_difference_with_borrow,
		op_const_difference_borrow,
		op_word_immediate_difference,
		op_and,
		op_conj_with_const,
		op_or,
		op_disj_with_const,
		op_xor_regs,
		op_bit_inversion,
		op_arith_inverse,
		op_mask_set_bits,
		op_mask_clear_bits,
		op_plus_one,
		op_minus_one,
		op_fill_ones,
		op_pc_offset_jump,
		op_pointer_jump,
		op_near_subroutine_call,
		op_pointer_subroutine_call,
		op_subroutine_exit,
		op_interrupt_exit,
		op_equal_compare_skip,
		op_compare,
		op_compare_with_borrow,
		op_compare_with_const,
		op_skip_reg_bit_clear,
		op_skip_reg_bit_set,
		op_skip_io_bit_clear,
		op_skip_io_bit_set
	} mab_op_t;

endpackage : mab_pkg

// >>> core/mab_core.sv
// Contract
// - Register add, optional carry, one cycle.
// - Word add immediate, two cycles, flags.
// - Subtract register or constant, one cycle.
// - Subtract with carry borrow, one cycle.
// - Word subtract immediate, two cycles.
// - AND register or constant; Z,N,V.
// - OR, XOR; one cycle; Z,N,V,S only.
// - Set masked bits, keep others.
// - Clear masked bits via 0xff minus mask.
// - Increment/decrement, carry unchanged.
// - Fill with ones, no flag change.
// - Jumps two cycles, pointer or relative.
// - Calls three cycles, returns four.
// - Skip when registers equal, 1/2/3.
// - Compares subtract without storing result.
// - Skip when register bit clear.
// - Skip when register bit set.
// - Skip when I/O bit clear.
// - Skip when I/O bit set.
`timescale 1ns/1ps
`include "mab_cfg.svh"

module mab_core (
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              op_valid,
	input  wire mab_pkg::mab_op_t  op,
	input  wire logic [4:0]        rd_idx,
	input  wire logic [4:0]        source_reg,
	input  wire logic [7:0]        imm,
	input  wire logic [2:0]        bit_sel,
	input  wire logic [11:0]       offset,
	input  wire logic              io_bit,
	input  wire logic              next_two_word,
	output logic                   ready_q,
	output logic                   retire_q,
	output logic [15:0]            pc_q,
	output logic [7:0]             sreg_q,
	output logic                   wr_valid_q,
	output logic                   wr_word_q,
	output logic [4:0]             wr_idx_q,
	output logic [15:0]            wr_data_q
);
	import mab_pkg::*;

	// ==========================================
	// State
	logic [7:0]  rf_q [32];
	logic [15:0] stk_q [16];
	logic [3:0]  sp_q;
	logic [1:0]  wait_q;

	logic        accept;
	logic [7:0]  a_val;
	logic [7:0]  b_val;
	logic [15:0] w_val;
	logic [15:0] w_res;
	logic [8:0]  sum9;
	logic [7:0]  res;
	logic        wr_en;
	logic        wr_word;
	logic [5:0]  fl;
	logic        fl_en;
	logic        set_i;
	logic        skip_take;
	logic [15:0] pc_d;
	logic [15:0] ptr_val;
	logic [2:0]  cyc_n;
	logic        push;
	logic        pop;

	assign accept  = op_valid && ready_q;
	assign a_val   = rf_q[rd_idx];
	assign w_val   = {rf_q[rd_idx + 5'h01], rf_q[rd_idx]};
	assign ptr_val = {rf_q[`MAB_PTR_HI], rf_q[`MAB_PTR_LO]};

	// ==========================================
	// Flag helper: returns {H,S,V,N,Z,C}
	function automatic logic [5:0] mab_arith_fl(
		input logic [7:0] a,
		input logic [7:0] b,
		input logic [7:0] r,
		input logic       sub,
		input logic       chain,
		input logic       z_old
	);
		logic h;
		logic c;
		logic v;
		logic z;
		if (sub)
		begin
			h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
			c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
			v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
		end
		else
		begin
			h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
			c = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
			v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
		end
		z = (r == 8'h00) & (chain ? z_old : 1'b1);
		return {h, r[7] ^ v, v, r[7], z, c};
	endfunction : mab_arith_fl

	// ==========================================
	// Datapath and flags
	always_comb
	begin
		b_val   = rf_q[source_reg];
		res     = 8'h00;
		sum9    = 9'h000;
		w_res   = 16'h0000;
		wr_en   = 1'b0;
		wr_word = 1'b0;
		fl      = sreg_q[5:0];
		fl_en   = 1'b0;
		set_i   = 1'b0;
		case (op)
			op_difference_const, op_const_difference_borrow, op_conj_with_const,
			op_disj_with_const, op_mask_set_bits, op_compare_with_const:
				b_val = imm;
			op_mask_clear_bits:
				b_val = `MAB_ALL_ONES - imm;
			default:
				b_val = rf_q[source_reg];
		endcase
		case (op)
			op_add, op_add_carry:
			begin
				sum9  = {1'b0, a_val} + {1'b0, b_val} + {8'h00, op == op_add_carry && sreg_q[`MAB_FL_C]};
				res   = sum9[7:0];
				wr_en = 1'b1;
				fl    = mab_arith_fl(a_val, b_val, res, 1'b0, 1'b0, 1'b0);
				fl_en = 1'b1;
			end
			op_sub, op_difference_const, op_difference_with_borrow, op_const_difference_borrow,
			op_compare, op_compare_with_borrow, op_compare_with_const:
			begin
				sum9  = {1'b0, a_val} - {1'b0, b_val} - {8'h00, sreg_q[`MAB_FL_C] &&
					(op == op_difference_with_borrow || op == op_const_difference_borrow ||
					op == op_compare_with_borrow)};
				res   = sum9[7:0];
				wr_en = !(op == op_compare || op == op_compare_with_borrow || op == op_compare_with_const);
				fl    = mab_arith_fl(a_val, b_val, res, 1'b1,
					op == op_difference_with_borrow || op == op_const_difference_borrow ||
					op == op_compare_with_borrow, sreg_q[`MAB_FL_Z]);
				fl_en = 1'b1;
			end
			op_word_immediate_sum, op_word_immediate_difference:
			begin
				w_res   = (op == op_word_immediate_sum) ? w_val + {10'h000, imm[5:0]} : w_val - {10'h000, imm[5:0]};
				res     = w_res[7:0];
				wr_en   = 1'b1;
				wr_word = 1'b1;
				fl[`MAB_FL_N] = w_res[15];
				fl[`MAB_FL_Z] = (w_res == 16'h0000);
				if (op == op_word_immediate_sum)
				begin
					fl[`MAB_FL_V] = ~w_val[15] & w_res[15];
					fl[`MAB_FL_C] = w_val[15] & ~w_res[15];
				end
				else
				begin
					fl[`MAB_FL_V] = w_val[15] & ~w_res[15];
					fl[`MAB_FL_C] = ~w_val[15] & w_res[15];
				end
				fl[`MAB_FL_S] = w_res[15] ^ fl[`MAB_FL_V];
				fl_en = 1'b1;
			end
			op_and, op_conj_with_const, op_or, op_disj_with_const, op_xor_regs,
			op_mask_set_bits, op_mask_clear_bits:
			begin
				if (op == op_or || op == op_disj_with_const || op == op_mask_set_bits)
					res = a_val | b_val;
				else if (op == op_xor_regs)
					res = a_val ^ b_val;
				else
					res = a_val & b_val;
				wr_en = 1'b1;
				fl[`MAB_FL_Z] = (res == 8'h00);
				fl[`MAB_FL_N] = res[7];
				fl[`MAB_FL_V] = 1'b0;
				fl[`MAB_FL_S] = res[7];
				fl_en = 1'b1;
			end
			op_bit_inversion, op_arith_inverse:
			begin
				res   = (op == op_bit_inversion) ? `MAB_ALL_ONES - a_val : 8'h00 - a_val;
				wr_en = 1'b1;
				fl    = mab_arith_fl(8'h00, a_val, res, 1'b1, 1'b0, 1'b0);
				if (op == op_bit_inversion)
				begin
					fl[`MAB_FL_H] = sreg_q[`MAB_FL_H];
					fl[`MAB_FL_V] = 1'b0;
					fl[`MAB_FL_C] = 1'b1;
					fl[`MAB_FL_S] = res[7];
				end
				fl_en = 1'b1;
			end
			op_plus_one, op_minus_one:
			begin
				res   = (op == op_plus_one) ? a_val + 8'h01 : a_val - 8'h01;
				wr_en = 1'b1;
				fl[`MAB_FL_Z] = (res == 8'h00);
				fl[`MAB_FL_N] = res[7];
				fl[`MAB_FL_V] = (op == op_plus_one) ? (res == 8'h80) : (res == 8'h7f);
				fl[`MAB_FL_S] = res[7] ^ fl[`MAB_FL_V];
				fl_en = 1'b1;
			end
			op_fill_ones:
			begin
				res   = `MAB_ALL_ONES;
				wr_en = 1'b1;
			end
			op_interrupt_exit:
				set_i = 1'b1;
			default:
				res = 8'h00;
		endcase
	end

	// ==========================================
	// Program counter, skips and cycle count
	always_comb
	begin
		skip_take = 1'b0;
		push      = 1'b0;
		pop       = 1'b0;
		cyc_n     = {1'b0, `MAB_CYC_ONE};
		pc_d      = pc_q + 16'h0001;
		case (op)
			op_equal_compare_skip:
				skip_take = (a_val == rf_q[source_reg]);
			op_skip_reg_bit_clear:
				skip_take = !rf_q[source_reg][bit_sel];
			op_skip_reg_bit_set:
				skip_take = rf_q[source_reg][bit_sel];
			op_skip_io_bit_clear:
				skip_take = !io_bit;
			op_skip_io_bit_set:
				skip_take = io_bit;
			op_word_immediate_sum, op_word_immediate_difference:
				cyc_n = {1'b0, `MAB_CYC_WORD};
			op_pc_offset_jump:
			begin
				pc_d  = pc_q + {{4{offset[11]}}, offset} + 16'h0001;
				cyc_n = {1'b0, `MAB_CYC_JUMP};
			end
			op_pointer_jump:
			begin
				pc_d  = ptr_val;
				cyc_n = {1'b0, `MAB_CYC_JUMP};
			end
			op_near_subroutine_call:
			begin
				pc_d  = pc_q + {{4{offset[11]}}, offset} + 16'h0001;
				push  = 1'b1;
				cyc_n = {1'b0, `MAB_CYC_CALL};
			end
			op_pointer_subroutine_call:
			begin
				pc_d  = ptr_val;
				push  = 1'b1;
				cyc_n = {1'b0, `MAB_CYC_CALL};
			end
			op_subroutine_exit, op_interrupt_exit:
			begin
				pc_d  = stk_q[sp_q - 4'h1];
				pop   = 1'b1;
				cyc_n = `MAB_CYC_RET;
			end
			default:
				cyc_n = {1'b0, `MAB_CYC_ONE};
		endcase
		if (skip_take)
		begin
			pc_d  = pc_q + (next_two_word ? 16'h0003 : 16'h0002);
			cyc_n = next_two_word ? 3'h3 : 3'h2;
		end
	end

	// ==========================================
	// Issue handshake and busy counter
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			ready_q  <= 1'b1;
			retire_q <= 1'b0;
			wait_q   <= 2'h0;
		end
		else if (accept)
		begin
			wait_q   <= 2'(cyc_n - 3'h1);
			ready_q  <= (cyc_n == 3'h1);
			retire_q <= (cyc_n == 3'h1);
		end
		else if (wait_q != 2'h0)
		begin
			wait_q   <= wait_q - 2'h1;
			ready_q  <= (wait_q == 2'h1);
			retire_q <= (wait_q == 2'h1);
		end
		else
		begin
			retire_q <= 1'b0;
		end
	end

	// ==========================================
	// Register file and write report
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < 32; i++)
				rf_q[i] <= 8'h00;
			wr_valid_q <= 1'b0;
			wr_word_q  <= 1'b0;
			wr_idx_q   <= 5'h00;
			wr_data_q  <= 16'h0000;
		end
		else
		begin
			wr_valid_q <= accept && wr_en;
			if (accept && wr_en)
			begin
				wr_word_q <= wr_word;
				wr_idx_q  <= rd_idx;
				wr_data_q <= wr_word ? w_res : {8'h00, res};
				rf_q[rd_idx] <= res;
				if (wr_word)
					rf_q[rd_idx + 5'h01] <= w_res[15:8];
			end
		end
	end

	// ==========================================
	// Status register and program counter
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			sreg_q <= `MAB_SREG_RESET;
			pc_q   <= `MAB_PC_RESET;
		end
		else if (accept)
		begin
			pc_q <= pc_d;
			if (fl_en)
				sreg_q[5:0] <= fl;
			if (set_i)
				sreg_q[`MAB_FL_I] <= 1'b1;
		end
	end

	// ==========================================
	// Return stack
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			sp_q <= 4'h0;
		else if (accept && push)
		begin
			stk_q[sp_q] <= pc_q + 16'h0001;
			sp_q        <= sp_q + 4'h1;
		end
		else if (accept && pop)
			sp_q <= sp_q - 4'h1;
	end

	// ==========================================
	// Assertions
	a_add_result: assert property (@(posedge clk) disable iff (!reset_n)
		accept && op == op_add |=> wr_valid_q && wr_data_q[7:0] == $past(a_val) + $past(rf_q[source_reg]))
		else $error("Register add result wrong");

	a_word_two_cycles: assert property (@(posedge clk) disable iff (!reset_n)
		accept && (op == op_word_immediate_sum || op == op_word_immediate_difference)
		|=> !ready_q ##1 ready_q && retire_q)
		else $error("Word operation not two cycles");

	a_sub_result: assert property (@(posedge clk) disable iff (!reset_n)
		accept && op == op_difference_const |=> wr_data_q[7:0] == $past(a_val) - $past(imm) && ready_q)
		else $error("Constant subtract wrong");

	a_logic_v_clear: assert property (@(posedge clk) disable iff (!reset_n)
		accept && (op == op_and || op == op_or || op == op_xor_regs)
		|=> !sreg_q[`MAB_FL_V] && sreg_q[`MAB_FL_C] == $past(sreg_q[`MAB_FL_C]))
		else $error("Logic op flags wrong");

	a_mask_clear: assert property (@(posedge clk) disable iff (!reset_n)
		accept && op == op_mask_clear_bits |=> wr_data_q[7:0] == ($past(a_val) & ~$past(imm)))
		else $error("Mask clear wrong");

	a_inc_keep_c: assert property (@(posedge clk) disable iff (!reset_n)
		accept && (op == op_plus_one || op == op_minus_one) |=> $stable(sreg_q[`MAB_FL_C]))
		else $error("Carry changed by step");

	a_fill_flags: assert property (@(posedge clk) disable iff (!reset_n)
		accept && op == op_fill_ones |=> $stable(sreg_q) && wr_data_q[7:0] == 8'hff)
		else $error("Fill ones wrong");

	a_jump_target: assert property (@(posedge clk) disable iff (!reset_n)
		accept && op == op_pc_offset_jump
		|=> pc_q == $past(pc_q) + {{4{$past(offset[11])}}, $past(offset)} + 16'h0001 && !ready_q ##1 ready_q)
		else $error("Relative jump wrong");

	a_call_cycles: assert property (@(posedge clk) disable iff (!reset_n)
		accept && (op == op_near_subroutine_call || op == op_pointer_subroutine_call)
		|=> !ready_q [*2] ##1 ready_q)
		else $error("Call not three cycles");

	a_ret_cycles: assert property (@(posedge clk) disable iff (!reset_n)
		accept && (op == op_subroutine_exit || op == op_interrupt_exit) |=> !ready_q [*3] ##1 ready_q)
		else $error("Return not four cycles");

	a_cmp_no_write: assert property (@(posedge clk) disable iff (!reset_n)
		accept && (op == op_compare || op == op_compare_with_const) |=> !wr_valid_q)
		else $error("Compare wrote result");

	a_skip_pc: assert property (@(posedge clk) disable iff (!reset_n)
		accept && op == op_skip_reg_bit_set && rf_q[source_reg][bit_sel]
		|=> pc_q == $past(pc_q) + ($past(next_two_word) ? 16'h0003 : 16'h0002))
		else $error("Bit skip target wrong");

	a_sign_rule: assert property (@(posedge clk) disable iff (!reset_n)
		accept && (op == op_add || op == op_sub || op == op_compare)
		|=> sreg_q[`MAB_FL_S] == (sreg_q[`MAB_FL_N] ^ sreg_q[`MAB_FL_V]))
		else $error("Sign flag not N xor V");

endmodule : mab_core

// >>> tb/mab_imem.sv
`timescale 1ns/1ps

// ==========================================
// Program memory side: presents one instruction at a time
module mab_imem (
	input  wire logic              clk,
	output logic                   op_valid,
	output mab_pkg::mab_op_t       op,
	output logic [4:0]             rd_idx,
	output logic [4:0]             source_reg,
	output logic [7:0]             imm,
	output logic [2:0]             bit_sel,
	output logic [11:0]            offset,
	output logic                   io_bit,
	output logic                   next_two_word
);
	import mab_pkg::*;

	initial
	begin
		op_valid = 1'h0;
		op = op_nop;
		rd_idx = 5'h00;
		source_reg = 5'h00;
		imm = 8'h00;
		bit_sel = 3'h0;
		offset = 12'h000;
		io_bit = 1'h0;
		next_two_word = 1'h0;
	end

	// Drive a word; caller holds it until the taking edge
	task automatic put(input mab_op_t o, input logic [4:0] d, input logic [4:0] s, input logic [7:0] k,
		input logic [2:0] b, input logic [11:0] f, input logic i, input logic w);
		op_valid = 1'h1;
		op = o;
		rd_idx = d;
		source_reg = s;
		imm = k;
		bit_sel = b;
		offset = f;
		io_bit = i;
		next_two_word = w;
	endtask : put

	// Released fields show inverted garbage; op keeps the old word's value
	task automatic drop();
		op_valid = 1'h0;
		rd_idx = ~rd_idx;
		source_reg = ~source_reg;
		imm = ~imm;
		bit_sel = ~bit_sel;
		offset = ~offset;
		io_bit = ~io_bit;
		next_two_word = ~next_two_word;
	endtask : drop
endmodule : mab_imem

// >>> tb/mab_core_test.sv
`timescale 1ns/1ps

module mab_core_test;
	import mab_pkg::*;

	logic              clk = 1'h0;
	logic              reset_n = 1'h0;
	logic              op_valid;
	mab_op_t           op;
	logic [4:0]        rd_idx;
	logic [4:0]        source_reg;
	logic [4:0]        last_rd;
	logic [7:0]        imm;
	logic [2:0]        bit_sel;
	logic [11:0]       offset;
	logic              io_bit;
	logic              next_two_word;
	logic              ready_q;
	logic              retire_q;
	logic [15:0]       pc_q;
	logic [7:0]        sreg_q;
	logic              wr_valid_q;
	logic              wr_word_q;
	logic [4:0]        wr_idx_q;
	logic [15:0]       wr_data_q;
	logic              wv;
	int                n_errors = 0;
	int                compares = 0;

	always #4 clk = ~clk;

	mab_imem i_mem (.clk(clk), .op_valid(op_valid), .op(op), .rd_idx(rd_idx), .source_reg(source_reg), .imm(imm),
		.bit_sel(bit_sel), .offset(offset), .io_bit(io_bit), .next_two_word(next_two_word));

	mab_core i_dut (.clk(clk), .reset_n(reset_n), .op_valid(op_valid), .op(op), .rd_idx(rd_idx),
		.source_reg(source_reg), .imm(imm), .bit_sel(bit_sel), .offset(offset), .io_bit(io_bit),
		.next_two_word(next_two_word), .ready_q(ready_q), .retire_q(retire_q), .pc_q(pc_q),
		.sreg_q(sreg_q), .wr_valid_q(wr_valid_q), .wr_word_q(wr_word_q), .wr_idx_q(wr_idx_q),
		.wr_data_q(wr_data_q));

	// ==========================================
	// Shared helpers
	task automatic summarize();
		$display("checks %0d, errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
		begin
			$display("TEST PASSED");
		end
		else
		begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
			n_errors++;
		end
	endtask : chk

	// Issue one word, count busy cycles to retire, check new pc
	task automatic run(input mab_op_t o, input logic [4:0] d, input logic [4:0] s, input logic [7:0] k,
		input logic [2:0] b, input logic [11:0] f, input logic i, input logic w,
		input logic [15:0] cyc, input logic [15:0] npc);
		logic [15:0] n;
		logic        done;
		n = 16'h0000;
		last_rd = d;
		@(negedge clk);
		while (ready_q !== 1'h1 && n < 16'h0014)
		begin
			@(negedge clk);
			n++;
		end
		if (ready_q !== 1'h1)
		begin
			n_errors++;
			summarize();
		end
		i_mem.put(o, d, s, k, b, f, i, w);
		@(posedge clk);
		#1;
		n = 16'h0001;
		wv = wr_valid_q;
		done = retire_q;
		@(negedge clk);
		i_mem.drop();
		while (done !== 1'h1 && n < 16'h0008)
		begin
			@(posedge clk);
			#1;
			n++;
			done = retire_q;
		end
		chk("cycles", n, cyc);
		chk("pc", pc_q, npc);
		if (done !== 1'h1)
		begin
			n_errors++;
			summarize();
		end
	endtask : run

	task automatic res(input logic [7:0] sr, input logic [15:0] dt);
		chk("sreg", {8'h00, sreg_q}, {8'h00, sr});
		chk("data", wr_data_q, dt);
		chk("idx", {11'h000, wr_idx_q}, {11'h000, last_rd});
		chk("wrote", {15'h0000, wv}, 16'h0001);
	endtask : res

	// ==========================================
	// Scenarios
	task automatic s_byte_ops();
		run(op_fill_ones, 5'h11, 5'h00, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h0001);
		res(8'h00, 16'h00ff);
		run(op_plus_one, 5'h12, 5'h00, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h0002);
		res(8'h00, 16'h0001);
		run(op_minus_one, 5'h13, 5'h00, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h0003);
		res(8'h14, 16'h00ff);
		run(op_add, 5'h11, 5'h12, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h0004);
		res(8'h23, 16'h0000);
		run(op_add_carry, 5'h12, 5'h12, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h0005);
		res(8'h00, 16'h0003);
		run(op_sub, 5'h12, 5'h13, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h0006);
		res(8'h21, 16'h0004);
		run(op_difference_with_borrow, 5'h12, 5'h11, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h0007);
		res(8'h00, 16'h0003);
	endtask : s_byte_ops

	task automatic s_logic_ops();
		run(op_conj_with_const, 5'h13, 5'h00, 8'h80, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h0008);
		res(8'h14, 16'h0080);
		run(op_xor_regs, 5'h13, 5'h13, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h0009);
		res(8'h02, 16'h0000);
		run(op_mask_clear_bits, 5'h12, 5'h00, 8'h01, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h000a);
		res(8'h00, 16'h0002);
		run(op_mask_set_bits, 5'h12, 5'h00, 8'h80, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h000b);
		res(8'h14, 16'h0082);
		run(op_arith_inverse, 5'h12, 5'h00, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h000c);
		res(8'h21, 16'h007e);
		run(op_compare_with_const, 5'h12, 5'h00, 8'h7f, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h000d);
		chk("sreg", {8'h00, sreg_q}, 16'h0035);
		chk("write", {15'h0000, wv}, 16'h0000);
	endtask : s_logic_ops

	task automatic s_word_ops();
		run(op_word_immediate_sum, 5'h18, 5'h00, 8'h3f, 3'h0, 12'h000, 1'h0, 1'h0, 16'h2, 16'h000e);
		res(8'h20, 16'h003f);
		chk("word", {15'h0000, wr_word_q}, 16'h0001);
		run(op_word_immediate_difference, 5'h18, 5'h00, 8'h01, 3'h0, 12'h000, 1'h0, 1'h0, 16'h2, 16'h000f);
		res(8'h20, 16'h003e);
	endtask : s_word_ops

	task automatic s_flow();
		run(op_pc_offset_jump, 5'h00, 5'h00, 8'h00, 3'h0, 12'h010, 1'h0, 1'h0, 16'h2, 16'h0020);
		run(op_pointer_jump, 5'h00, 5'h00, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h2, 16'h0000);
		run(op_near_subroutine_call, 5'h00, 5'h00, 8'h00, 3'h0, 12'hffe, 1'h0, 1'h0, 16'h3, 16'hffff);
		run(op_subroutine_exit, 5'h00, 5'h00, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h4, 16'h0001);
		run(op_pointer_subroutine_call, 5'h00, 5'h00, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h3, 16'h0000);
		run(op_interrupt_exit, 5'h00, 5'h00, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h4, 16'h0002);
		chk("sreg", {8'h00, sreg_q}, 16'h00a0);
	endtask : s_flow

	task automatic s_skips();
		run(op_skip_reg_bit_set, 5'h00, 5'h12, 8'h00, 3'h1, 12'h000, 1'h0, 1'h1, 16'h3, 16'h0005);
		run(op_skip_reg_bit_clear, 5'h00, 5'h12, 8'h00, 3'h1, 12'h000, 1'h0, 1'h0, 16'h1, 16'h0006);
		run(op_skip_io_bit_clear, 5'h00, 5'h00, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h2, 16'h0008);
		run(op_skip_io_bit_set, 5'h00, 5'h00, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h0009);
		run(op_equal_compare_skip, 5'h11, 5'h13, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h2, 16'h000b);
		chk("sreg", {8'h00, sreg_q}, 16'h00a0);
	endtask : s_skips

	task automatic s_more_ops();
		run(op_difference_const, 5'h12, 5'h00, 8'h7f, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h000c);
		res(8'hb5, 16'h00ff);
		run(op_const_difference_borrow, 5'h12, 5'h00, 8'h0f, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h000d);
		res(8'hb4, 16'h00ef);
		run(op_and, 5'h12, 5'h18, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h000e);
		res(8'ha0, 16'h002e);
		run(op_or, 5'h11, 5'h12, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h000f);
		res(8'ha0, 16'h002e);
		run(op_disj_with_const, 5'h11, 5'h00, 8'h80, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h0010);
		res(8'hb4, 16'h00ae);
		run(op_bit_inversion, 5'h11, 5'h00, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h0011);
		res(8'ha1, 16'h0051);
		run(op_compare, 5'h11, 5'h11, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h0012);
		chk("sreg", {8'h00, sreg_q}, 16'h0082);
		chk("write", {15'h0000, wv}, 16'h0000);
		run(op_compare_with_borrow, 5'h11, 5'h12, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h0013);
		chk("sreg", {8'h00, sreg_q}, 16'h00a0);
		chk("write", {15'h0000, wv}, 16'h0000);
	endtask : s_more_ops

	task automatic s_reset();
		@(negedge clk);
		reset_n = 1'h0;
		repeat (2) @(negedge clk);
		reset_n = 1'h1;
		chk("pc", pc_q, 16'h0000);
		chk("sreg", {8'h00, sreg_q}, 16'h0000);
		chk("wdata", wr_data_q, 16'h0000);
		chk("widx", {11'h000, wr_idx_q}, 16'h0000);
		chk("ready", {15'h0000, ready_q}, 16'h0001);
		run(op_add, 5'h11, 5'h12, 8'h00, 3'h0, 12'h000, 1'h0, 1'h0, 16'h1, 16'h0001);
		res(8'h02, 16'h0000);
	endtask : s_reset

	// ==========================================
	// Main sequence
	initial
	begin
		repeat (4) @(negedge clk);
		reset_n = 1'h1;
		chk("pc", pc_q, 16'h0000);
		chk("sreg", {8'h00, sreg_q}, 16'h0000);
		chk("ready", {15'h0000, ready_q}, 16'h0001);
		s_byte_ops();
		s_logic_ops();
		s_word_ops();
		s_flow();
		s_skips();
		s_more_ops();
		s_reset();
		summarize();
	end
endmodule : mab_core_test
